// File: design/wwd_pkg.sv
// Constants for the windowed watchdog and clock monitor.
// Assumes a 100 MHz mclk and an AXI4-Lite register bus with 32-bit data.
package wwd_pkg;

   // Register byte offsets
   localparam logic [7:0]  SVC_OFFS        = 8'h00;
   localparam logic [7:0]  STAT_OFFS       = 8'h04;

   // Service register fields
   localparam int          WIN_MSB         = 7;
   localparam int          WIN_LSB         = 6;
   localparam int          KEY_MSB         = 5;
   localparam int          KEY_LSB         = 1;
   localparam int          CMEN_BIT        = 0;
   localparam logic [4:0]  KEY_PATTERN     = 5'h0C;
   localparam logic [1:0]  WIN_RESET       = 2'h3;
   localparam logic        CMEN_RESET      = 1'b1;

   // Status register fields
   localparam int          ST_FAULT_BIT    = 0;
   localparam int          ST_CMERR_BIT    = 1;
   localparam int          ST_LOCK_BIT     = 2;
   localparam int          ST_BOOT_BIT     = 3;
   localparam int          ST_ARMED_BIT    = 4;
   localparam int          ST_ELAPSED_LSB  = 8;

   // Window limits in idle timer clocks
   localparam int          ELAPSED_W       = 17;
   localparam logic [16:0] LOWER_LIMIT     = 17'h00800;
   localparam logic [16:0] UPPER_BASE      = 17'h02000;

   // Fault pin release delay, within the 16 to 32 cycle band
   localparam int          HOLD_W          = 5;
   localparam logic [4:0]  FAULT_HOLD_CYC  = 5'h14;

   // Clock monitor timeout: between 200 us (5 kHz) and 100 ms (10 Hz)
   localparam int          CLK_MHZ         = 100;
   localparam int          CM_TIMEOUT_MS   = 10;
   localparam int          CM_TIMEOUT_CYC  = CM_TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int          CM_W            = 24;

   // AXI responses
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // Fault sequencer states
   typedef enum logic [3:0] {
      FS_IDLE   = 4'b0001,
      FS_DRIVE  = 4'b0010,
      FS_HOLD   = 4'b0100,
      FS_WAITHI = 4'b1000
   } wwd_fault_e;

endpackage : wwd_pkg

// File: design/wwd_top.sv
// Windowed watchdog with key-protected service register and clock monitor.
// Assumes idle timer ticks, mode and boot strobes come from mclk logic;
// the fault pin level and instruction clock ticks arrive from outside.
// What this block does
// - Service register: window select bits 7:6, key bits 5:1, monitor enable bit 0.
// - Matching key is fixed pattern 01100; software writes it on every service.
// - Lower service limit fixed at 2048 idle timer clocks.
// - Window select 0..3 gives upper limits 8k, 16k, 32k, 64k clocks.
// - Monitor enable bit 0 gates only the clock monitor's pin drive; the monitor error flag still sets.
// - All watchdog intervals count idle timer clocks.
// - Option bit low enables watchdog and makes port G bit 1 its output.
// - Inactive in reset; afterwards armed, window 11, monitor enabled.
// - Instruction clock too slow after reset raises a clock monitor error.
// - First key-matching write latches window and monitor enable until reset.
// - Later writes must match all fields; match restarts, mismatch errors.
// - Upper limit expiry without valid service is a watchdog error.
// - Service before the lower limit since the last one is an error.
// - Boot ROM entry suppresses lower-window error and services immediately.
// - Boot ROM services within upper limit and again on return.
// - On error drive pin low, hold 16-32 cycles after sensed low, release.
// - Service window restarts when the fault pin returns high.
// - Service writes during an active fault are ignored.
// - Clock error holds pin low until clock recovers, then 16-32 cycles.
// - Never reject instruction clock of 5 kHz, always reject below 10 Hz.
// - Reading the service register returns zeros in the key field.
// - Watchdog inhibited in halt and idle; clock monitor stays active.
// - Leaving idle mode performs a hardware service.
`timescale 1ns/100ps
module wwd_top #(
   parameter int CM_TIMEOUT = wwd_pkg::CM_TIMEOUT_CYC
) (
   // Clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        clkEn,
   // AXI4-Lite write address
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic [2:0]  awprot,
   // AXI4-Lite write data
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // AXI4-Lite write response
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // AXI4-Lite read address
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   input  wire logic [2:0]  arprot,
   // AXI4-Lite read data
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // Core side events
   input  wire logic        optWdOff,
   input  wire logic        idleTick,
   input  wire logic        haltMode,
   input  wire logic        idleMode,
   input  wire logic        idleExit,
   input  wire logic        bootEnter,
   input  wire logic        bootExit,
   // Instruction clock tick from the oscillator domain
   input  wire logic        instrTick,
   // Fault pin (port_g_bit1), open drain
   input  wire logic        faultPinIn,
   output logic             faultPinOut,
   output logic             faultPinOeN
);

   // Register state
   logic [1:0]             winSel_q;
   logic                   cmEn_q;
   logic                   locked_q;
   logic                   lowerArmed_q;
   logic                   bootActive_q;
   logic [16:0]            elapsed_q;
   wwd_pkg::wwd_fault_e    fState_q;
   logic [4:0]             holdCnt_q;
   logic [23:0]            cmCnt_q;
   logic                   cmErr_q;
   logic [4:0]             cmRel_q;
   logic                   drvN_q;
   logic                   pinS1_q, pinS2_q;
   logic                   tckS1_q, tckS2_q, tckPrev_q;
   logic                   bvalid_q, rvalid_q, rdIsSvc_q;
   logic [1:0]             bresp_q, rresp_q;
   logic [31:0]            rdata_q;

   // Assertion clock and reset
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   function automatic logic [16:0] upperLimit(input logic [1:0] sel);
      return wwd_pkg::UPPER_BASE << sel;
   endfunction : upperLimit

   // Bus handshakes
   logic wrFire, rdFire, svcWrite;
   assign awready     = clkEn & awvalid & wvalid & ~bvalid_q;
   assign wready      = awready;
   assign arready     = clkEn & ~rvalid_q;
   assign wrFire      = awready;
   assign rdFire      = arvalid & arready;
   assign svcWrite    = wrFire & (awaddr == wwd_pkg::SVC_OFFS) & wstrb[0];
   assign bvalid      = bvalid_q;
   assign bresp       = bresp_q;
   assign rvalid      = rvalid_q;
   assign rdata       = rdata_q;
   assign rresp       = rresp_q;
   assign faultPinOut = 1'b0;
   assign faultPinOeN = drvN_q;

   // Service decode
   logic       wdOn, inFault, keyOk, fullOk, early, svcOk, svcBad, wdRun, expire;
   logic       wdErr, hwSvc, pinHigh, restart;
   logic [7:0] wByte;
   assign wByte   = wdata[7:0];
   assign wdOn    = ~optWdOff;
   assign inFault = (fState_q != wwd_pkg::FS_IDLE);
   assign keyOk   = (wByte[wwd_pkg::KEY_MSB:wwd_pkg::KEY_LSB] == wwd_pkg::KEY_PATTERN);
   assign fullOk  = keyOk & (wByte[wwd_pkg::WIN_MSB:wwd_pkg::WIN_LSB] == winSel_q)
                    & (wByte[wwd_pkg::CMEN_BIT] == cmEn_q);
   assign early   = lowerArmed_q & ~bootActive_q
                    & (elapsed_q < wwd_pkg::LOWER_LIMIT);
   assign svcOk   = wdOn & svcWrite & ~inFault
                    & (locked_q ? (fullOk & ~early) : keyOk);
   assign svcBad  = wdOn & svcWrite & ~inFault
                    & ~(locked_q ? (fullOk & ~early) : keyOk);
   assign wdRun   = wdOn & ~inFault & ~haltMode & ~idleMode;
   assign expire  = wdRun & (elapsed_q >= upperLimit(winSel_q));
   assign wdErr   = svcBad | expire;
   assign hwSvc   = wdOn & ~inFault & (idleExit | bootEnter | bootExit);
   assign pinHigh = pinS2_q;
   assign restart = svcOk | hwSvc;

   // Pin and tick synchronisers
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pinS1_q   <= 1'b1;
         pinS2_q   <= 1'b1;
         tckS1_q   <= 1'b0;
         tckS2_q   <= 1'b0;
         tckPrev_q <= 1'b0;
      end else if (clkEn) begin
         pinS1_q   <= faultPinIn;
         pinS2_q   <= pinS1_q;
         tckS1_q   <= instrTick;
         tckS2_q   <= tckS1_q;
         tckPrev_q <= tckS2_q;
      end
   end

   // Service register and configuration lock
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         winSel_q <= wwd_pkg::WIN_RESET;
         cmEn_q   <= wwd_pkg::CMEN_RESET;
         locked_q <= 1'b0;
      end else if (clkEn && svcOk && !locked_q) begin
         winSel_q <= wByte[wwd_pkg::WIN_MSB:wwd_pkg::WIN_LSB];
         cmEn_q   <= wByte[wwd_pkg::CMEN_BIT];
         locked_q <= 1'b1;
      end
   end

   // Lower window arming and boot ROM tracking
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         lowerArmed_q <= 1'b0;
         bootActive_q <= 1'b0;
      end else if (clkEn) begin
         if (bootEnter) begin
            bootActive_q <= 1'b1;
         end else if (bootExit) begin
            bootActive_q <= 1'b0;
         end
         if (svcOk || (hwSvc && !bootEnter)) begin
            lowerArmed_q <= 1'b1;
         end
      end
   end

   // Elapsed idle timer count
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         elapsed_q <= '0;
      end else if (clkEn) begin
         if (restart || (fState_q == wwd_pkg::FS_WAITHI && pinHigh)) begin
            elapsed_q <= '0;
         end else if (wdRun && idleTick && !expire) begin
            elapsed_q <= elapsed_q + 17'h00001;
         end
      end
   end

   // Watchdog fault sequencer
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         fState_q  <= wwd_pkg::FS_IDLE;
         holdCnt_q <= '0;
      end else if (clkEn) begin
         case (fState_q)
            wwd_pkg::FS_IDLE: begin
               if (wdErr) begin
                  fState_q <= wwd_pkg::FS_DRIVE;
               end
            end
            wwd_pkg::FS_DRIVE: begin
               holdCnt_q <= '0;
               if (!pinHigh) begin
                  fState_q <= wwd_pkg::FS_HOLD;
               end
            end
            wwd_pkg::FS_HOLD: begin
               holdCnt_q <= holdCnt_q + 5'h01;
               if (holdCnt_q == wwd_pkg::FAULT_HOLD_CYC - 5'h01) begin
                  fState_q <= wwd_pkg::FS_WAITHI;
               end
            end
            wwd_pkg::FS_WAITHI: begin
               if (pinHigh) begin
                  fState_q <= wwd_pkg::FS_IDLE;
               end
            end
            default: fState_q <= wwd_pkg::FS_IDLE;
         endcase
      end
   end

   // Clock monitor: timeout on instruction clock ticks
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cmCnt_q <= '0;
         cmErr_q <= 1'b0;
         cmRel_q <= '0;
      end else if (clkEn) begin
         if (tckS2_q && !tckPrev_q) begin
            cmCnt_q <= '0;
            cmErr_q <= 1'b0;
         end else if (cmCnt_q >= CM_TIMEOUT[23:0] - 24'h000001) begin
            cmErr_q <= 1'b1;
         end else begin
            cmCnt_q <= cmCnt_q + 24'h000001;
         end
         if (cmErr_q) begin
            cmRel_q <= wwd_pkg::FAULT_HOLD_CYC;
         end else if (cmRel_q != 5'h00) begin
            cmRel_q <= cmRel_q - 5'h01;
         end
      end
   end

   // Shared fault pin drive, released to the weak pull-up
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         drvN_q <= 1'b1;
      end else if (clkEn) begin
         drvN_q <= ~(wdOn & ((fState_q == wwd_pkg::FS_DRIVE)
                  | (fState_q == wwd_pkg::FS_HOLD)
                  | (cmEn_q & (cmErr_q | (cmRel_q != 5'h00)))));
      end
   end

   // AXI write response
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= wwd_pkg::RESP_OKAY;
      end else if (clkEn) begin
         if (wrFire) begin
            bvalid_q <= 1'b1;
            if (awaddr == wwd_pkg::SVC_OFFS || awaddr == wwd_pkg::STAT_OFFS) begin
               bresp_q <= wwd_pkg::RESP_OKAY;
            end else begin
               bresp_q <= wwd_pkg::RESP_SLVERR;
            end
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // AXI read data
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= wwd_pkg::RESP_OKAY;
         rdIsSvc_q <= 1'b0;
      end else if (clkEn) begin
         if (rdFire) begin
            rvalid_q  <= 1'b1;
            rdIsSvc_q <= (araddr == wwd_pkg::SVC_OFFS);
            rresp_q   <= wwd_pkg::RESP_OKAY;
            rdata_q   <= '0;
            if (araddr == wwd_pkg::SVC_OFFS) begin
               rdata_q[wwd_pkg::WIN_MSB:wwd_pkg::WIN_LSB] <= winSel_q;
               rdata_q[wwd_pkg::CMEN_BIT]                 <= cmEn_q;
            end else if (araddr == wwd_pkg::STAT_OFFS) begin
               rdata_q[wwd_pkg::ST_FAULT_BIT] <= inFault;
               rdata_q[wwd_pkg::ST_CMERR_BIT] <= cmErr_q;
               rdata_q[wwd_pkg::ST_LOCK_BIT]  <= locked_q;
               rdata_q[wwd_pkg::ST_BOOT_BIT]  <= bootActive_q;
               rdata_q[wwd_pkg::ST_ARMED_BIT] <= lowerArmed_q;
               rdata_q[wwd_pkg::ST_ELAPSED_LSB +: wwd_pkg::ELAPSED_W] <= elapsed_q;
            end else begin
               rresp_q <= wwd_pkg::RESP_SLVERR;
            end
         end else if (rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Checks
   a_reset_defaults: assert property (disable iff (1'b0) !nrst |=>
      (winSel_q == 2'h3) && cmEn_q && !locked_q && drvN_q && fState_q == wwd_pkg::FS_IDLE)
      else $error("state after reset wrong");
   a_key_readback: assert property (rvalid_q && rdIsSvc_q |->
      rdata_q[5:1] == 5'h00)
      else $error("key field visible on read");
   a_config_frozen: assert property (locked_q && clkEn |=>
      $stable(winSel_q) && $stable(cmEn_q))
      else $error("configuration changed after lock");
   a_upper_expiry: assert property (clkEn && wdRun &&
      elapsed_q >= upperLimit(winSel_q) |=> fState_q == wwd_pkg::FS_DRIVE)
      else $error("upper limit expiry missed");
   a_early_service: assert property (clkEn && svcWrite && wdOn && !inFault && locked_q
      && lowerArmed_q && !bootActive_q && elapsed_q < 17'h00800 |=> fState_q == wwd_pkg::FS_DRIVE)
      else $error("early service not flagged");
   a_fault_ignore: assert property (svcWrite && inFault |->
      !svcOk && !svcBad)
      else $error("service during fault acted upon");
   a_hold_release: assert property (clkEn && fState_q == wwd_pkg::FS_HOLD &&
      holdCnt_q == 5'h13 |=> fState_q == wwd_pkg::FS_WAITHI)
      else $error("fault hold length wrong");
   a_drive_low: assert property (clkEn && wdOn && fState_q == wwd_pkg::FS_HOLD
      |=> !drvN_q)
      else $error("pin not driven during hold");
   a_cm_drive: assert property (clkEn && wdOn && cmEn_q && cmErr_q |=> !drvN_q)
      else $error("clock error not driving pin");
   a_restart_high: assert property (clkEn && fState_q == wwd_pkg::FS_WAITHI && pinHigh
      |=> elapsed_q == 17'h00000 && fState_q == wwd_pkg::FS_IDLE)
      else $error("window not restarted on pin high");
   a_option_off: assert property (clkEn && optWdOff |=> drvN_q)
      else $error("pin driven with watchdog absent");

endmodule : wwd_top

// File: verification/wwd_ext_model.sv
// Far side of the watchdog: fault pin with weak pull-up, instruction clock source.
// Assumes the block pulls the pin open drain, enable low while pulling.
`timescale 1ns/100ps
module wwd_ext_model #(
   parameter real HALF_NS = 173.0
) (
   // Fault pin
   input  wire logic faultPinOut,
   input  wire logic faultPinOeN,
   output logic      faultPinIn,
   // Instruction clock
   input  wire logic clkRun,
   output logic      instrTick
);
   // Released pin floats up to the pull-up level
   assign faultPinIn = faultPinOeN ? 1'b1 : faultPinOut;
   // Dead oscillator stands still at its last level
   initial begin
      instrTick = 1'b0;
      forever begin
         #(HALF_NS);
         if (clkRun) instrTick = ~instrTick;
      end
   end
endmodule : wwd_ext_model

// File: verification/tb_wwd_top.sv
// Self-checking bench for the windowed watchdog and clock monitor.
// Assumes the external model supplies the pin level and instruction clock.
`timescale 1ns/100ps
module tb_wwd_top;
   localparam int          CM_T = 200;
   localparam int          UPC  = 2 * int'(wwd_pkg::UPPER_BASE);
   localparam int          LOWC = 2 * int'(wwd_pkg::LOWER_LIMIT) + 100;
   localparam logic [31:0] SVC0 = {24'h000000, 2'h0, wwd_pkg::KEY_PATTERN, 1'b1};
   localparam logic [7:0]  SA   = wwd_pkg::SVC_OFFS;
   localparam logic [7:0]  TA   = wwd_pkg::STAT_OFFS;
   localparam logic [1:0]  OK   = wwd_pkg::RESP_OKAY;
   localparam logic [1:0]  ER   = wwd_pkg::RESP_SLVERR;
   // Clock, reset, bus
   logic        mclk = 1'b0, nrst = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000, rdata;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   // Core events, pin, instruction clock
   logic        optWdOff = 1'b0, idleTick = 1'b0, haltMode = 1'b0, idleMode = 1'b0;
   logic        idleExit = 1'b0, bootEnter = 1'b0, bootExit = 1'b0, clkRun = 1'b1;
   logic        instrTick, faultPinIn, faultPinOut, faultPinOeN;
   int          errCount = 0, checksDone = 0;
   logic [31:0] bad [3] = '{SVC0 ^ 32'h00000040, SVC0 ^ 32'h00000002, SVC0 ^ 32'h00000001};

   always #5 mclk = ~mclk;
   // One idle timer clock every other cycle
   always @(posedge mclk) idleTick <= ~idleTick;

   wwd_top #(.CM_TIMEOUT(CM_T)) wwd_top_i (
      .mclk(mclk), .nrst(nrst), .clkEn(1'b1),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .optWdOff(optWdOff), .idleTick(idleTick), .haltMode(haltMode), .idleMode(idleMode),
      .idleExit(idleExit), .bootEnter(bootEnter), .bootExit(bootExit),
      .instrTick(instrTick), .faultPinIn(faultPinIn), .faultPinOut(faultPinOut),
      .faultPinOeN(faultPinOeN)
   );

   wwd_ext_model wwd_ext_model_i (
      .faultPinOut(faultPinOut), .faultPinOeN(faultPinOeN), .faultPinIn(faultPinIn),
      .clkRun(clkRun), .instrTick(instrTick)
   );

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checksDone, errCount);
      if (errCount == 0 && checksDone > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         errCount++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic tmo(input int n);
      if (n >= 100) begin
         errCount++;
         $display("MISMATCH bus handshake expected answer seen none");
         end_of_test();
      end
   endtask : tmo

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      @(negedge mclk);
      for (n = 0; n < 100 && !(awready === 1'b1 && wready === 1'b1); n++) @(negedge mclk);
      tmo(n);
      @(posedge mclk);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      @(negedge mclk);
      for (n = 0; n < 100 && bvalid !== 1'b1; n++) @(negedge mclk);
      tmo(n);
      chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge mclk);
      bready <= 1'b0;
      @(posedge mclk);
   endtask : wr

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp, input logic [1:0] er);
      int n;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      @(negedge mclk);
      for (n = 0; n < 100 && arready !== 1'b1; n++) @(negedge mclk);
      tmo(n);
      @(posedge mclk);
      arvalid <= 1'b0;
      @(negedge mclk);
      for (n = 0; n < 100 && rvalid !== 1'b1; n++) @(negedge mclk);
      tmo(n);
      chk(nm, exp, rdata & m);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge mclk);
      rready <= 1'b0;
      @(posedge mclk);
   endtask : rd

   // Looks for the pin pulled low within lim cycles
   task automatic seeFault(input string nm, input logic exp, input int lim);
      int n;
      @(negedge mclk);
      for (n = 0; n < lim && faultPinOeN !== 1'b0; n++) @(negedge mclk);
      chk(nm, {31'h0, exp}, {31'h0, faultPinOeN === 1'b0});
      @(posedge mclk);
   endtask : seeFault

   // Cycles until the pin is released must fall in lo..hi
   task automatic seeRelease(input string nm, input int lo, input int hi);
      int n;
      @(negedge mclk);
      for (n = 0; n < 400 && faultPinOeN !== 1'b1; n++) @(negedge mclk);
      chk(nm, 32'h1, {31'h0, n >= lo && n <= hi});
      // Let the synchronised pin return the sequencer to idle
      repeat (4) @(posedge mclk);
   endtask : seeRelease

   task automatic doReset();
      nrst <= 1'b0;
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
   endtask : doReset

   initial begin
      time t0;
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      rd("svc reset", SA, 32'hFF, {24'h0, wwd_pkg::WIN_RESET, 5'h00, wwd_pkg::CMEN_RESET}, OK);
      rd("lock reset", TA, 32'h4, 32'h0, OK);
      rd("unmapped rd", 8'h08, 32'hFFFFFFFF, 32'h0, ER);
      wr(8'h10, SVC0, ER);
      wr(SA, SVC0, OK);
      rd("svc config", SA, 32'hFF, 32'h01, OK);
      rd("lock set", TA, 32'h14, 32'h14, OK);
      $display("test config done");
      wr(SA, SVC0, OK);
      seeFault("early svc", 1'b1, 50);
      rd("fault on", TA, 32'h1, 32'h1, OK);
      wr(SA, SVC0, OK);
      seeRelease("release", 0, 36);
      seeFault("ignored svc", 1'b0, 300);
      for (int i = 0; i < 3; i++) begin
         repeat (LOWC) @(posedge mclk);
         wr(SA, bad[i], OK);
         seeFault("bad field", 1'b1, 50);
         seeRelease("hold", 17, 36);
      end
      $display("test service errors done");
      repeat (LOWC) @(posedge mclk);
      wr(SA, SVC0, OK);
      t0 = $time;
      seeFault("late svc", 1'b0, 100);
      seeFault("expiry", 1'b1, UPC);
      chk("expiry time", 32'h1, {31'h0, ($time - t0) / 10 >= UPC - 8 && ($time - t0) / 10 <= UPC + 8});
      seeRelease("hold", 17, 36);
      $display("test expiry done");
      bootEnter <= 1'b1;
      @(posedge mclk);
      bootEnter <= 1'b0;
      rd("boot on", TA, 32'h8, 32'h8, OK);
      wr(SA, SVC0, OK);
      seeFault("boot svc", 1'b0, 100);
      bootExit <= 1'b1;
      @(posedge mclk);
      bootExit <= 1'b0;
      wr(SA, SVC0, OK);
      seeFault("after boot", 1'b1, 50);
      seeRelease("hold", 17, 36);
      repeat (LOWC) @(posedge mclk);
      idleExit <= 1'b1;
      @(posedge mclk);
      idleExit <= 1'b0;
      wr(SA, SVC0, OK);
      seeFault("idle exit", 1'b1, 50);
      seeRelease("hold", 17, 36);
      haltMode <= 1'b1;
      repeat (LOWC) @(posedge mclk);
      haltMode <= 1'b0;
      wr(SA, SVC0, OK);
      seeFault("halt freeze", 1'b1, 50);
      seeRelease("hold", 17, 36);
      $display("test boot and low power done");
      clkRun <= 1'b0;
      doReset();
      seeFault("no clock", 1'b1, CM_T + 100);
      repeat (300) @(posedge mclk);
      chk("clk held", 32'h0, {31'h0, faultPinOeN});
      rd("cm err", TA, 32'h2, 32'h2, OK);
      clkRun <= 1'b1;
      seeRelease("clk back", 16, 80);
      doReset();
      wr(SA, SVC0 ^ 32'h00000001, OK);
      clkRun <= 1'b0;
      seeFault("monitor off", 1'b0, CM_T + 100);
      clkRun <= 1'b1;
      $display("test clock monitor done");
      optWdOff <= 1'b1;
      doReset();
      wr(SA, SVC0 ^ 32'h00000002, OK);
      seeFault("option off", 1'b0, 100);
      $display("test option done");
      end_of_test();
   end
endmodule : tb_wwd_top
